// ==== acmp_pkg.sv ====
// constants, register map and field layout of the comparator control block
// assumes a 32-bit apb slave port and a single 250 MHz clock
package acmp_pkg;

  // ==========================================================================
  // register map: printed offsets are indices, byte address is four times
  localparam int unsigned ADDR_W        = 12;
  localparam logic [7:0]  CSR_IDX       = 8'h50;
  localparam logic [7:0]  IMASK_IDX     = 8'h51;
  localparam logic [7:0]  CONVB_IDX     = 8'h7B;
  localparam logic [1:0]  WORD_PAD      = 2'h0;

  // ==========================================================================
  // comparator_control_status fields
  localparam int unsigned CSR_OFF_BIT   = 7;
  localparam int unsigned CSR_REF_BIT   = 6;
  localparam int unsigned CSR_RES_BIT   = 5;
  localparam int unsigned CSR_FLAG_BIT  = 4;
  localparam int unsigned CSR_IE_BIT    = 3;
  localparam int unsigned CSR_CAP_BIT   = 2;
  localparam int unsigned CSR_MODE_HI   = 1;
  localparam int unsigned CSR_MODE_LO   = 0;
  localparam logic        CSR_BIT_RST   = 1'b0;
  localparam logic [1:0]  MODE_RST      = 2'h0;

  // ==========================================================================
  // converter_control_b fields
  localparam int unsigned CONVB_MUX_BIT = 6;
  localparam int unsigned TRIG_W        = 3;
  localparam logic [2:0]  TRIG_RST      = 3'h0;

  // ==========================================================================
  // event modes
  localparam logic [1:0]  MODE_TOGGLE   = 2'h0;
  localparam logic [1:0]  MODE_RSVD     = 2'h1;
  localparam logic [1:0]  MODE_FALL     = 2'h2;
  localparam logic [1:0]  MODE_RISE     = 2'h3;

  // ==========================================================================
  // misc
  localparam int unsigned NUM_CHAN      = 8;
  localparam int unsigned SEL_W         = 3;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
  localparam int unsigned SYNC_FILL     = 3;
  localparam logic [2:0]  FILL_RST      = 3'h0;

  // apb state machine
  typedef enum logic [2:0] {
    ACMP_IDLE   = 3'b001,
    ACMP_ACCESS = 3'b010,
    ACMP_DONE   = 3'b100
  } acmp_apb_st_t;

  function automatic logic [ADDR_W-1:0] acmp_byte_addr(input logic [7:0] idx);
    acmp_byte_addr = {2'h0, idx, WORD_PAD};
  endfunction

endpackage

// ==== acmp_evt_if.sv ====
// signals between the control module and the synchroniser/edge module
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface acmp_evt_if;
  logic       cmp_raw;
  logic       hold;
  logic [1:0] mode;
  logic       result;
  logic       evt;

  modport ctrl_mp (output cmp_raw, output hold, output mode, input result, input evt);
  modport edge_mp (input cmp_raw, input hold, input mode, output result, output evt);
endinterface

// ==== acmp_sync_edge.sv ====
// synchroniser and event detector for the comparator output
// assumes raw comparator output may be asynchronous to ref_clk_i
`timescale 1ns/1ns
module acmp_sync_edge
  import acmp_pkg::*;
(
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  // link to control
  acmp_evt_if.edge_mp evt_if
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic [SYNC_FILL-1:0] fill_q;

  // events wait until prev_q holds a settled level, otherwise the first
  // synchronised level after reset would look like an output edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fill_q <= FILL_RST;
    end else begin
      fill_q <= {fill_q[SYNC_FILL-2:0], 1'b1};
    end
  end

  // ==========================================================================
  // synchroniser: first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b0;
    end else begin
      sync1_q <= evt_if.cmp_raw;
    end
  end

  // frozen while off so no new output transition appears
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      if (!evt_if.hold) begin
        sync2_q <= sync1_q;
      end
      prev_q <= sync2_q;
    end
  end

  assign evt_if.result = sync2_q;

  // ==========================================================================
  // event select
  always_comb begin
    case (evt_if.mode)
      MODE_TOGGLE: evt_if.evt = sync2_q ^ prev_q;
      MODE_FALL:   evt_if.evt = prev_q & ~sync2_q;
      MODE_RISE:   evt_if.evt = sync2_q & ~prev_q;
      default:     evt_if.evt = 1'b0;
    endcase
    if (!fill_q[SYNC_FILL-1]) begin
      evt_if.evt = 1'b0;
    end
  end

endmodule

// ==== acmp_ctrl.sv ====
// top of the comparator control block: apb registers, input select, interrupt
// assumes analog levels arrive as sampled codes synchronous to ref_clk_i
`timescale 1ns/1ns
module acmp_ctrl
  import acmp_pkg::*;
#(
  parameter int unsigned         LVL_W   = 10,
  parameter logic [LVL_W-1:0]    REF_LVL = 10'h1C2
)(
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // apb slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [ADDR_W-1:0]      paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  // analog levels
  input  wire logic [LVL_W-1:0]       positive_pin_i,
  input  wire logic [LVL_W-1:0]       negative_pin_i,
  input  wire logic [NUM_CHAN*LVL_W-1:0] converter_channels_i,
  // converter and processor state
  input  wire logic                   converter_enable_i,
  input  wire logic [SEL_W-1:0]       channel_select_i,
  input  wire logic                   converter_power_reduce_i,
  input  wire logic                   global_irq_enable_i,
  input  wire logic                   irq_vector_ack_i,
  // outputs to the rest of the chip
  output logic                        irq_o,
  output logic                        capture_trig_o,
  output logic                        comparator_off_o,
  output logic                        neg_mux_active_o,
  output logic [TRIG_W-1:0]           trigger_select_o
);

  // ==========================================================================
  // reset release
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ==========================================================================
  // register state
  logic              off_q;
  logic              ref_sel_q;
  logic              flag_q;
  logic              flag_d;
  logic              ie_q;
  logic              cap_en_q;
  logic [1:0]        mode_q;
  logic              mask_q;
  logic              mux_en_q;
  logic [TRIG_W-1:0] trig_q;

  // ==========================================================================
  // apb slave: one wait state, answer on the second access cycle
  acmp_apb_st_t st_q;
  acmp_apb_st_t st_d;
  logic         wr_fire;
  logic         hit_csr;
  logic         hit_mask;
  logic         hit_convb;
  logic         hit_any;
  logic [31:0]  rdata_d;
  logic         acc_phase;
  logic         csr_wr;

  assign hit_csr   = (paddr_i == acmp_byte_addr(CSR_IDX));
  assign hit_mask  = (paddr_i == acmp_byte_addr(IMASK_IDX));
  assign hit_convb = (paddr_i == acmp_byte_addr(CONVB_IDX));
  assign hit_any   = hit_csr | hit_mask | hit_convb;
  assign wr_fire   = psel_i & penable_i & pready_o & pwrite_i;
  assign acc_phase = (st_q == ACMP_ACCESS) & psel_i & penable_i;
  assign csr_wr    = wr_fire & hit_csr;

  always_comb begin
    case (st_q)
      ACMP_IDLE:   st_d = (psel_i && !penable_i) ? ACMP_ACCESS : ACMP_IDLE;
      ACMP_ACCESS: st_d = (psel_i && penable_i) ? ACMP_DONE : ACMP_IDLE;
      ACMP_DONE:   st_d = (psel_i && !penable_i) ? ACMP_ACCESS : ACMP_IDLE;
      default:     st_d = ACMP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ACMP_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // read mux: reserved bits stay zero
  always_comb begin
    rdata_d = RDATA_ZERO;
    if (hit_csr) begin
      rdata_d[CSR_OFF_BIT]  = off_q;
      rdata_d[CSR_REF_BIT]  = ref_sel_q;
      rdata_d[CSR_RES_BIT]  = evt_if.result;
      rdata_d[CSR_FLAG_BIT] = flag_q;
      rdata_d[CSR_IE_BIT]   = ie_q;
      rdata_d[CSR_CAP_BIT]  = cap_en_q;
      rdata_d[CSR_MODE_HI]  = mode_q[1];
      rdata_d[CSR_MODE_LO]  = mode_q[0];
    end else if (hit_mask) begin
      rdata_d[CSR_FLAG_BIT] = mask_q;
    end else if (hit_convb) begin
      rdata_d[CONVB_MUX_BIT]   = mux_en_q;
      rdata_d[TRIG_W-1:0]      = trig_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= acc_phase;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= acc_phase & ~hit_any;
    end
  end

  // zero outside the answer cycle keeps stale data off the bus
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prdata_o <= RDATA_ZERO;
    end else if (acc_phase && !pwrite_i) begin
      prdata_o <= rdata_d;
    end else begin
      prdata_o <= RDATA_ZERO;
    end
  end

  // ==========================================================================
  // control fields
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      off_q <= CSR_BIT_RST;
    end else if (csr_wr) begin
      off_q <= pwdata_i[CSR_OFF_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ref_sel_q <= CSR_BIT_RST;
    end else if (csr_wr) begin
      ref_sel_q <= pwdata_i[CSR_REF_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ie_q <= CSR_BIT_RST;
    end else if (csr_wr) begin
      ie_q <= pwdata_i[CSR_IE_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cap_en_q <= CSR_BIT_RST;
    end else if (csr_wr) begin
      cap_en_q <= pwdata_i[CSR_CAP_BIT];
    end
  end

  // mode changes with the interrupt enabled may raise a stray event
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q <= MODE_RST;
    end else if (csr_wr) begin
      mode_q <= pwdata_i[CSR_MODE_HI:CSR_MODE_LO];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mask_q <= CSR_BIT_RST;
    end else if (wr_fire && hit_mask) begin
      mask_q <= pwdata_i[CSR_FLAG_BIT];
    end
  end

  // only the mux enable and trigger select bits are stored
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mux_en_q <= CSR_BIT_RST;
      trig_q   <= TRIG_RST;
    end else if (wr_fire && hit_convb) begin
      mux_en_q <= pwdata_i[CONVB_MUX_BIT];
      trig_q   <= pwdata_i[TRIG_W-1:0];
    end
  end

  // ==========================================================================
  // input selection and compare
  function automatic logic [LVL_W-1:0] chan_pick(
    input logic [NUM_CHAN*LVL_W-1:0] lvls,
    input logic [SEL_W-1:0]          sel
  );
    chan_pick = lvls[sel*LVL_W +: LVL_W];
  endfunction

  logic             mux_active;
  logic [LVL_W-1:0] pos_lvl;
  logic [LVL_W-1:0] neg_lvl;

  // power reduction also blocks the channel path, matching the converter's gating
  assign mux_active = mux_en_q & ~converter_enable_i & ~converter_power_reduce_i;
  assign neg_lvl    = mux_active ? chan_pick(converter_channels_i, channel_select_i)
                                 : negative_pin_i;
  assign pos_lvl    = ref_sel_q ? REF_LVL : positive_pin_i;

  acmp_evt_if evt_if ();

  assign evt_if.cmp_raw = (pos_lvl > neg_lvl);
  assign evt_if.hold    = off_q;
  assign evt_if.mode    = mode_q;

  acmp_sync_edge u_sync_edge (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_q),
    .evt_if  (evt_if.edge_mp)
  );

  // ==========================================================================
  // interrupt flag: a new event wins over a clear in the same cycle
  always_comb begin
    flag_d = flag_q;
    if (irq_vector_ack_i) begin
      flag_d = 1'b0;
    end
    if (wr_fire && hit_csr && pwdata_i[CSR_FLAG_BIT]) begin
      flag_d = 1'b0;
    end
    if (evt_if.evt && !off_q) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flag_q <= CSR_BIT_RST;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= flag_q & ie_q & mask_q & global_irq_enable_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      capture_trig_o <= 1'b0;
    end else begin
      capture_trig_o <= cap_en_q & evt_if.result;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      comparator_off_o <= 1'b0;
    end else begin
      comparator_off_o <= off_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      neg_mux_active_o <= 1'b0;
    end else begin
      neg_mux_active_o <= mux_active;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      trigger_select_o <= TRIG_RST;
    end else begin
      trigger_select_o <= trig_q;
    end
  end

endmodule

// ==== acmp_ctrl_properties.sv ====
// port checker for the comparator control block
// assumes it is bound into acmp_ctrl and sees one clock domain
`timescale 1ns/1ns
module acmp_ctrl_properties
  import acmp_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              rst_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              converter_enable_i,
  input wire logic              converter_power_reduce_i,
  input wire logic              global_irq_enable_i,
  input wire logic              irq_o,
  input wire logic              comparator_off_o,
  input wire logic              neg_mux_active_o,
  input wire logic [TRIG_W-1:0] trigger_select_o
);
  // ==========================================================================
  // helpers
  logic hit;
  logic done_w;
  logic [TRIG_W-1:0] wr_trig;
  logic              wr_off;
  assign wr_trig = pwdata_i[TRIG_W-1:0];
  assign wr_off  = pwdata_i[7];
  assign hit    = paddr_i == 12'h140 || paddr_i == 12'h144 || paddr_i == 12'h1EC;
  assign done_w = pready_o && psel_i && penable_i && pwrite_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_answer;
    !pready_o ##1 pready_o;
  endsequence
  // ==========================================================================
  // properties
  a_one_wait: assert property (s_setup |=> s_answer) else $error("late apb answer");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready held");
  a_err_map: assert property (pready_o |-> pslverr_o == !hit) else $error("bad pslverr");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("stale rdata");
  a_rsvd_zero: assert property (pready_o && !pwrite_i && paddr_i == 12'h1EC
    |-> prdata_o[31:7] == 25'h0 && prdata_o[5:3] == 3'h0) else $error("reserved bits set");
  a_trig_copy: assert property (done_w && paddr_i == 12'h1EC
    |-> ##2 trigger_select_o == $past(wr_trig, 2)) else $error("trigger select not copied");
  a_off_copy: assert property (done_w && paddr_i == 12'h140
    |-> ##2 comparator_off_o == $past(wr_off, 2)) else $error("off bit not copied");
  a_mux_gate: assert property ((converter_enable_i || converter_power_reduce_i) [*3]
    |-> !neg_mux_active_o) else $error("mux active while converter busy");
  a_irq_gate: assert property (!global_irq_enable_i [*2] |-> !irq_o)
    else $error("irq without global enable");
endmodule

bind acmp_ctrl acmp_ctrl_properties u_props (.ref_clk_i, .rst_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .converter_enable_i,
  .converter_power_reduce_i, .global_irq_enable_i, .irq_o, .comparator_off_o,
  .neg_mux_active_o, .trigger_select_o);

// ==== acmp_ctrl_tb.sv ====
// self-checking bench for acmp_ctrl, apb master and level stimulus
// assumes the design package and the bound checker are compiled first
`timescale 1ns/1ns
module acmp_ctrl_tb;
  import acmp_pkg::*;
  localparam logic [11:0] A_CSR = {2'h0, CSR_IDX, 2'h0};
  localparam logic [11:0] A_MSK = {2'h0, IMASK_IDX, 2'h0};
  localparam logic [11:0] A_CB  = {2'h0, CONVB_IDX, 2'h0};
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, prdy, perr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0]  pos = 10'h200, neg = 10'h100;
  logic [79:0] chans = 80'h0;
  logic [2:0]  csel = 3'h0, trig;
  logic cen = 0, pr = 0, gie = 0, ack = 0, irq, cap, off, mux, er, ef, e;
  int err_total = 0, num_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  acmp_ctrl #(.LVL_W(10), .REF_LVL(10'h1C2)) dut (.ref_clk_i(clk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr), .positive_pin_i(pos),
    .negative_pin_i(neg), .converter_channels_i(chans), .converter_enable_i(cen),
    .channel_select_i(csel), .converter_power_reduce_i(pr), .global_irq_enable_i(gie),
    .irq_vector_ack_i(ack), .irq_o(irq), .capture_trig_o(cap), .comparator_off_o(off),
    .neg_mux_active_o(mux), .trigger_select_o(trig));
  // ==========================================================================
  // common tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1;
    pen    <= 0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prdata;
    e  = perr;
    psel <= 0;
    pen  <= 0;
  endtask
  // result needs the synchroniser to settle before a read
  task automatic lvl(input logic hi);
    neg <= hi ? 10'h100 : 10'h300;
    repeat (6) @(posedge clk);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    apb(0, A_CSR, 0);
    chk(rd & 32'hDF, 0);
    apb(0, A_CB, 0);
    chk(rd, 0);
    apb(0, 12'h148, 0);
    chk(rd, 0);
    chk(32'(e), 1);
    apb(1, A_CB, 32'hFF);
    apb(0, A_CB, 0);
    chk(rd, 32'h47);
    chk(32'(trig), 7);
  endtask
  task automatic t_mux();
    apb(1, A_CB, 32'h40);
    for (int s = 0; s < 8; s++) begin
      chans <= 80'h3FF << (s * 10);
      csel  <= 3'(s);
      repeat (6) @(posedge clk);
      apb(0, A_CSR, 0);
      chk(32'(rd[5]), 0);
      chk(32'(mux), 1);
    end
    apb(1, A_CB, 0);
    apb(0, A_CSR, 0);
    chk(32'(rd[5]), 1);
    chk(32'(mux), 0);
    apb(1, A_CB, 32'h40);
    cen <= 1;
    lvl(1);
    apb(0, A_CSR, 0);
    chk(32'(rd[5]), 1);
    chk(32'(mux), 0);
    cen <= 0;
    pr  <= 1;
    lvl(1);
    apb(0, A_CSR, 0);
    chk(32'(rd[5]), 1);
    chk(32'(mux), 0);
    apb(1, A_CB, 0);
    pr <= 0;
  endtask
  task automatic t_ref();
    apb(1, A_CSR, 32'h40);
    pos <= 10'h0;
    lvl(1);
    apb(0, A_CSR, 0);
    chk(32'(rd[5]), 1);
    lvl(0);
    apb(0, A_CSR, 0);
    chk(32'(rd[5]), 0);
    apb(1, A_CSR, 0);
    pos <= 10'h100;
    lvl(1);
    apb(0, A_CSR, 0);
    chk(32'(rd[5]), 0);
    pos <= 10'h200;
  endtask
  task automatic t_modes();
    apb(1, A_MSK, 32'h10);
    gie <= 1;
    for (int m = 0; m < 4; m++) begin
      er = m == 0 || m == 3;
      ef = m == 0 || m == 2;
      lvl(0);
      apb(1, A_CSR, 32'h10 | m);
      apb(1, A_CSR, 32'h18 | m);
      lvl(1);
      apb(0, A_CSR, 0);
      chk(32'(rd[4]), 32'(er));
      chk(32'(irq), 32'(er));
      apb(1, A_CSR, 32'h08 | m);
      apb(0, A_CSR, 0);
      chk(32'(rd[4]), 32'(er));
      apb(1, A_CSR, 32'h18 | m);
      apb(0, A_CSR, 0);
      chk(32'(rd[4]), 0);
      lvl(0);
      apb(0, A_CSR, 0);
      chk(32'(rd[4]), 32'(ef));
      ack <= 1;
      @(posedge clk);
      ack <= 0;
      repeat (2) @(posedge clk);
      apb(0, A_CSR, 0);
      chk(32'(rd[4]), 0);
    end
    lvl(1);
    chk(32'(irq), 1);
    gie <= 0;
    repeat (3) @(posedge clk);
    chk(32'(irq), 0);
    gie <= 1;
    apb(1, A_CSR, 32'h03);
    repeat (2) @(posedge clk);
    chk(32'(irq), 0);
    apb(1, A_CSR, 32'h0B);
    repeat (2) @(posedge clk);
    chk(32'(irq), 1);
  endtask
  task automatic t_off();
    apb(1, A_CSR, 32'h00);
    apb(1, A_CSR, 32'h90);
    repeat (2) @(posedge clk);
    chk(32'(off), 1);
    lvl(0);
    lvl(1);
    apb(0, A_CSR, 0);
    chk(32'(rd[4]), 0);
    apb(1, A_CSR, 32'h00);
    repeat (2) @(posedge clk);
    chk(32'(off), 0);
  endtask
  task automatic t_cap();
    apb(1, A_CSR, 32'h04);
    lvl(0);
    chk(32'(cap), 0);
    neg <= 10'h100;
    @(posedge clk);
    chk(32'(cap), 0);
    repeat (3) @(posedge clk);
    chk(32'(cap), 1);
    apb(1, A_CSR, 32'h00);
    repeat (2) @(posedge clk);
    chk(32'(cap), 0);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    t_regs();
    t_mux();
    t_ref();
    t_modes();
    t_off();
    t_cap();
    print_verdict();
  end
endmodule
